// ---- port_pin_function_select.sv ----
// Port pin function selector for ports A, B, C with alternate timer and SPI functions
//
// Operation
// - NMI latched on falling edge, asynchronously
// - Port A lines: inputs, irq, outputs, analog
// - Port B low lines: same, no analog
// - Timer input taken from line six input
// - Control bit routes timer output to line seven
// - Port C lines: inputs, analog, outputs; irq mode only pulls up, raises no interrupt
// - Port C lines carry SPI data and clock
// - Test pin high at reset enters programming
// - Reset pin holds all configuration cleared
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

module port_pin_function_select (
	// Clock, reset, enable
	input  wire logic        CLOCK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic        CE_IN,
	// Register port
	input  wire logic [7:0]  ADDR_IN,
	input  wire logic [7:0]  WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [7:0]  RDATA_OUT,
	// Pads: port A[3:0], B[7:0] (bits 4,5 absent), C[4:2] in bits 2..0
	input  wire logic [3:0]  PA_PAD_IN,
	output logic      [3:0]  PA_PAD_OUT,
	output logic      [3:0]  PA_PAD_OE_OUT,
	output logic      [3:0]  PA_PULL_OUT,
	output logic      [3:0]  PA_ANALOG_OUT,
	input  wire logic [7:0]  PB_PAD_IN,
	output logic      [7:0]  PB_PAD_OUT,
	output logic      [7:0]  PB_PAD_OE_OUT,
	output logic      [7:0]  PB_PULL_OUT,
	input  wire logic [2:0]  PC_PAD_IN,
	output logic      [2:0]  PC_PAD_OUT,
	output logic      [2:0]  PC_PAD_OE_OUT,
	output logic      [2:0]  PC_PULL_OUT,
	output logic      [2:0]  PC_ANALOG_OUT,
	// Special pins
	input  wire logic        NMI_N_IN,
	input  wire logic        TEST_HV_IN,
	// Peripheral side
	input  wire logic        TIMER_OUT_IN,
	output logic             TIMER_IN_OUT,
	input  wire logic        SPI_DOUT_IN,
	input  wire logic        SPI_SCK_IN,
	input  wire logic        SPI_SCK_OE_IN,
	output logic             SPI_DIN_OUT,
	output logic             SPI_SCK_OUT,
	// Status
	output logic             NMI_REQ_OUT,
	output logic             PROG_MODE_OUT,
	output logic             IRQ_OUT
);

	logic [7:0]  pa_data_q, pb_data_q, pc_data_q;
	logic [11:0] pa_mode_q;
	logic [23:0] pb_mode_q;
	logic [8:0]  pc_mode_q;
	logic [1:0]  alt_q;
	logic [11:0] irq_stat_q, irq_en_q, irq_set;
	logic [11:0] irq_clr;
	logic [13:0] sync1_q, sync2_q, prev_q;
	logic        nmi_edge_q, nmi_s1_q, nmi_s2_q, nmi_ack_q;
	logic        prog_q, test_s1_q, test_s2_q, rst_seen_q;
	logic [7:0]  rdata_d;
	logic [3:0]  pa_sync;
	logic [7:0]  pb_sync;
	logic [2:0]  pc_sync;
	logic [11:0] line_in;
	logic        wr_en;

	assign wr_en = CE_IN && WR_IN;

	// Decode one three-bit line mode into pad controls
	function automatic pinmux_pkg::pad_ctrl_t decode(input logic [2:0] m, input logic d);
		pinmux_pkg::pad_ctrl_t p;
		p = '0;
		case (pinmux_pkg::line_mode_t'(m))
			pinmux_pkg::MODE_IN_PULL,
			pinmux_pkg::MODE_IN_IRQ:    p.pull = 1'b1;
			pinmux_pkg::MODE_OPEN_DRN: begin
				p.out = 1'b0;
				p.oe  = ~d;
			end
			pinmux_pkg::MODE_PUSH_PULL: begin
				p.out = d;
				p.oe  = 1'b1;
			end
			pinmux_pkg::MODE_ANALOG:    p.ana = 1'b1;
			default:                    p = '0;
		endcase
		return p;
	endfunction : decode

	// Register writes; reset clears every configuration bit
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pa_data_q <= pinmux_pkg::DATA_RST;
			pb_data_q <= pinmux_pkg::DATA_RST;
			pc_data_q <= pinmux_pkg::DATA_RST;
			pa_mode_q <= pinmux_pkg::MODE_RST[11:0];
			pb_mode_q <= pinmux_pkg::MODE_RST;
			pc_mode_q <= pinmux_pkg::MODE_RST[8:0];
			alt_q     <= pinmux_pkg::ALT_RST;
			irq_en_q  <= pinmux_pkg::IRQ_RST;
		end else if (wr_en) begin
			case (ADDR_IN)
				pinmux_pkg::PA_DATA_OFS: pa_data_q <= WDATA_IN;
				pinmux_pkg::PB_DATA_OFS: pb_data_q <= WDATA_IN;
				pinmux_pkg::PC_DATA_OFS: pc_data_q <= WDATA_IN;
				// Mode registers: port B shifts in three bytes; ports A and C load from one byte, low bits repeated on top
				pinmux_pkg::PA_MODE_OFS: pa_mode_q <= {WDATA_IN[3:0], WDATA_IN[7:0]};
				pinmux_pkg::PB_MODE_OFS: pb_mode_q <= {pb_mode_q[15:0], WDATA_IN};
				pinmux_pkg::PC_MODE_OFS: pc_mode_q <= {WDATA_IN[0], WDATA_IN};
				pinmux_pkg::ALT_CTRL_OFS: alt_q <= WDATA_IN[1:0];
				pinmux_pkg::IRQ_EN_OFS:  irq_en_q <= {WDATA_IN[3:0], WDATA_IN};
				default: ;
			endcase
		end
	end

	// Two-flop synchronisers for pads and NMI
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sync1_q   <= '0;
			sync2_q   <= '0;
			prev_q    <= '0;
			nmi_s1_q  <= 1'b0;
			nmi_s2_q  <= 1'b0;
		end else if (CE_IN) begin
			sync1_q   <= {PC_PAD_IN, PB_PAD_IN[7:6], PB_PAD_IN[3:0], PA_PAD_IN, 1'b0};
			sync2_q   <= sync1_q;
			prev_q    <= sync2_q;
			nmi_s1_q  <= nmi_edge_q;
			nmi_s2_q  <= nmi_s1_q;
		end
	end

	// Strap synchroniser runs through reset so the level is settled at release
	always_ff @(posedge CLOCK_IN) begin
		if (CE_IN) begin
			test_s1_q <= TEST_HV_IN;
			test_s2_q <= test_s1_q;
		end
	end

	assign pa_sync = sync2_q[4:1];
	assign pb_sync = {sync2_q[10:9], 2'b00, sync2_q[8:5]};
	assign pc_sync = sync2_q[13:11];
	assign line_in = {pb_sync[7:6], pb_sync[3:0], pa_sync, 2'b00};

	// Asynchronous falling-edge catch, cleared once the core has seen it
	always_ff @(negedge NMI_N_IN or posedge nmi_ack_q or negedge RST_N_IN) begin
		if (!RST_N_IN)
			nmi_edge_q <= 1'b0;
		else if (nmi_ack_q)
			nmi_edge_q <= 1'b0;
		else
			nmi_edge_q <= 1'b1;
	end

	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			nmi_ack_q <= 1'b0;
		else if (CE_IN)
			nmi_ack_q <= nmi_s2_q && !nmi_ack_q;
	end

	// Programming mode strap caught in the first cycle after release
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			prog_q     <= 1'b0;
			rst_seen_q <= 1'b0;
		end else if (CE_IN && !rst_seen_q) begin
			prog_q     <= test_s2_q;
			rst_seen_q <= 1'b1;
		end
	end

	// Input-interrupt events: falling edge on port A and B lines in interrupt mode
	always_comb begin
		irq_set = '0;
		for (int i = 0; i < 4; i++) begin
			if (pa_mode_q[3*i +: 3] == pinmux_pkg::MODE_IN_IRQ && prev_q[1+i] && !sync2_q[1+i])
				irq_set[i] = 1'b1;
		end
		for (int i = 0; i < 4; i++) begin
			if (pb_mode_q[3*i +: 3] == pinmux_pkg::MODE_IN_IRQ && prev_q[5+i] && !sync2_q[5+i])
				irq_set[4+i] = 1'b1;
		end
		for (int i = 0; i < 2; i++) begin
			if (pb_mode_q[3*(6+i) - 6 +: 3] == pinmux_pkg::MODE_IN_IRQ && prev_q[9+i] && !sync2_q[9+i])
				irq_set[8+i] = 1'b1;
		end
		if (nmi_ack_q)
			irq_set[pinmux_pkg::IRQ_NMI_BIT] = 1'b1;
	end

	assign irq_clr = (wr_en && ADDR_IN == pinmux_pkg::IRQ_CLR_OFS) ? {WDATA_IN[3:0], WDATA_IN} : '0;

	// Sticky status; a set in the clearing cycle survives
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			irq_stat_q <= pinmux_pkg::IRQ_RST;
		else if (CE_IN)
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
	end

	assign IRQ_OUT       = |(irq_stat_q & irq_en_q);
	assign NMI_REQ_OUT   = irq_stat_q[pinmux_pkg::IRQ_NMI_BIT];
	assign PROG_MODE_OUT = prog_q;

	// Pad drive for port A
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pinmux_pkg::pad_ctrl_t p;
			p = decode(pa_mode_q[3*i +: 3], pa_data_q[i]);
			PA_PAD_OUT[i]    = p.out;
			PA_PAD_OE_OUT[i] = p.oe;
			PA_PULL_OUT[i]   = p.pull;
			PA_ANALOG_OUT[i] = p.ana;
		end
	end

	// Pad drive for port B; analog folded to plain input
	always_comb begin
		PB_PAD_OUT    = '0;
		PB_PAD_OE_OUT = '0;
		PB_PULL_OUT   = '0;
		for (int i = 0; i < 6; i++) begin
			pinmux_pkg::pad_ctrl_t p;
			int k;
			k = (i < 4) ? i : i + 2;
			p = decode(pb_mode_q[3*i +: 3], pb_data_q[k]);
			PB_PAD_OUT[k]    = p.out;
			PB_PAD_OE_OUT[k] = p.oe;
			PB_PULL_OUT[k]   = p.pull;
		end
		if (alt_q[pinmux_pkg::ALT_TIMER_OUT_BIT]) begin
			PB_PAD_OUT[7]    = TIMER_OUT_IN;
			PB_PAD_OE_OUT[7] = 1'b1;
		end
	end

	// Timer input sees the synchronised line six only while configured as input with or without pull, not in interrupt mode
	assign TIMER_IN_OUT = (pb_mode_q[14:12] == pinmux_pkg::MODE_IN_NOPULL ||
	                       pb_mode_q[14:12] == pinmux_pkg::MODE_IN_PULL) ? pb_sync[6] : 1'b0;

	// Pad drive for port C with SPI override
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pinmux_pkg::pad_ctrl_t p;
			p = decode(pc_mode_q[3*i +: 3], pc_data_q[i]);
			PC_PAD_OUT[i]    = p.out;
			PC_PAD_OE_OUT[i] = p.oe;
			PC_PULL_OUT[i]   = p.pull;
			PC_ANALOG_OUT[i] = p.ana;
		end
		if (alt_q[pinmux_pkg::ALT_SPI_BIT]) begin
			PC_PAD_OE_OUT[0] = 1'b0;
			PC_PAD_OUT[0]    = 1'b0;
			PC_PAD_OUT[1]    = SPI_DOUT_IN;
			PC_PAD_OE_OUT[1] = 1'b1;
			PC_PAD_OUT[2]    = SPI_SCK_IN;
			PC_PAD_OE_OUT[2] = SPI_SCK_OE_IN;
			PC_ANALOG_OUT    = '0;
		end
	end

	assign SPI_DIN_OUT = pc_sync[0];
	assign SPI_SCK_OUT = pc_sync[2];

	// Read mux, data one cycle after the strobe
	always_comb begin
		case (ADDR_IN)
			pinmux_pkg::PA_DATA_OFS:   rdata_d = pa_data_q;
			pinmux_pkg::PB_DATA_OFS:   rdata_d = pb_data_q;
			pinmux_pkg::PC_DATA_OFS:   rdata_d = pc_data_q;
			pinmux_pkg::PA_MODE_OFS:   rdata_d = pa_mode_q[7:0];
			pinmux_pkg::PB_MODE_OFS:   rdata_d = pb_mode_q[7:0];
			pinmux_pkg::PC_MODE_OFS:   rdata_d = pc_mode_q[7:0];
			pinmux_pkg::PA_PIN_OFS:    rdata_d = {4'h0, pa_sync};
			pinmux_pkg::PB_PIN_OFS:    rdata_d = pb_sync;
			pinmux_pkg::PC_PIN_OFS:    rdata_d = {5'h00, pc_sync};
			pinmux_pkg::ALT_CTRL_OFS:  rdata_d = {6'h00, alt_q};
			pinmux_pkg::IRQ_STAT_OFS:  rdata_d = irq_stat_q[7:0];
			pinmux_pkg::IRQ_EN_OFS:    rdata_d = irq_en_q[7:0];
			pinmux_pkg::PROG_STAT_OFS: rdata_d = {irq_stat_q[11:8], 3'h0, prog_q};
			default:                   rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			RDATA_OUT <= 8'h00;
		else if (CE_IN)
			RDATA_OUT <= RD_IN ? rdata_d : 8'h00;
	end

	// Checks
	AST_NMI_STAT: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		CE_IN && nmi_ack_q |=> NMI_REQ_OUT) else $error("nmi not latched");
	AST_PA_PP: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		pa_mode_q[2:0] == pinmux_pkg::MODE_PUSH_PULL |-> PA_PAD_OE_OUT[0] && PA_PAD_OUT[0] == pa_data_q[0])
		else $error("port a push pull wrong");
	AST_PB_NOANA: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		pb_mode_q[2:0] == pinmux_pkg::MODE_ANALOG |-> !PB_PULL_OUT[0] && !PB_PAD_OE_OUT[0])
		else $error("port b analog line driven");
	AST_PA_ANA: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		pa_mode_q[2:0] == pinmux_pkg::MODE_ANALOG |-> PA_ANALOG_OUT[0] && !PA_PAD_OE_OUT[0])
		else $error("port a analog wrong");
	AST_IRQ_SET: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		CE_IN && irq_set[4] |=> irq_stat_q[4]) else $error("line event lost");
	AST_IRQ_HOLD: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		CE_IN && irq_stat_q[4] && !irq_clr[4] |=> irq_stat_q[4]) else $error("status not sticky");
	AST_TMR_IN: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		pb_mode_q[14:12] == pinmux_pkg::MODE_PUSH_PULL |-> !TIMER_IN_OUT) else $error("timer input leak");
	AST_TMR_OUT: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		alt_q[0] |-> PB_PAD_OE_OUT[7] && PB_PAD_OUT[7] == TIMER_OUT_IN) else $error("timer output not routed");
	AST_PC_OD: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		!alt_q[1] && pc_mode_q[2:0] == pinmux_pkg::MODE_OPEN_DRN |-> !PC_PAD_OUT[0] && PC_PAD_OE_OUT[0] == !pc_data_q[0])
		else $error("port c open drain wrong");
	AST_SPI: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		alt_q[1] |-> PC_PAD_OE_OUT[1] && !PC_PAD_OE_OUT[0]) else $error("spi routing wrong");
	AST_PROG: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		rst_seen_q && CE_IN |=> $stable(PROG_MODE_OUT)) else $error("prog mode changed");
	AST_RST: assert property (@(posedge CLOCK_IN) !RST_N_IN |-> alt_q == 2'h0 && !IRQ_OUT)
		else $error("reset state wrong");
	COV_NMI: cover property (@(posedge CLOCK_IN) NMI_REQ_OUT);
	COV_SPI: cover property (@(posedge CLOCK_IN) alt_q[1] && PC_PAD_OE_OUT[2]);
	COV_IRQ: cover property (@(posedge CLOCK_IN) IRQ_OUT);
	COV_PROG: cover property (@(posedge CLOCK_IN) PROG_MODE_OUT);

endmodule : port_pin_function_select

// ---- pinmux_pkg.sv ----
// Package: register map, field layouts and pin mode encodings for the port pin function selector
package pinmux_pkg;

	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] PA_DATA_OFS    = 8'h00;
	localparam logic [7:0] PB_DATA_OFS    = 8'h04;
	localparam logic [7:0] PC_DATA_OFS    = 8'h08;
	localparam logic [7:0] PA_MODE_OFS    = 8'h0c;
	localparam logic [7:0] PB_MODE_OFS    = 8'h10;
	localparam logic [7:0] PC_MODE_OFS    = 8'h14;
	localparam logic [7:0] PA_PIN_OFS     = 8'h18;
	localparam logic [7:0] PB_PIN_OFS     = 8'h1c;
	localparam logic [7:0] PC_PIN_OFS     = 8'h20;
	localparam logic [7:0] ALT_CTRL_OFS   = 8'h24;
	localparam logic [7:0] IRQ_STAT_OFS   = 8'h28;
	localparam logic [7:0] IRQ_CLR_OFS    = 8'h2c;
	localparam logic [7:0] IRQ_EN_OFS     = 8'h30;
	localparam logic [7:0] PROG_STAT_OFS  = 8'h34;

	// Reset values
	localparam logic [7:0]  DATA_RST  = 8'h00;
	localparam logic [23:0] MODE_RST  = 24'h000000;
	localparam logic [1:0]  ALT_RST   = 2'h0;
	localparam logic [11:0] IRQ_RST   = 12'h000;

	// Alternate-function control bit positions
	localparam int ALT_TIMER_OUT_BIT = 0;
	localparam int ALT_SPI_BIT       = 1;

	// Interrupt status layout: [3:0] A, [9:4] B (0..3,6,7), [10] unused, [11] NMI
	localparam int IRQ_NMI_BIT = 11;

	// Per-line mode, three bits each
	typedef enum logic [2:0] {
		MODE_IN_NOPULL = 3'h0,
		MODE_IN_PULL   = 3'h1,
		MODE_IN_IRQ    = 3'h3,
		MODE_OPEN_DRN  = 3'h2,
		MODE_PUSH_PULL = 3'h6,
		MODE_ANALOG    = 3'h7
	} line_mode_t;

	// Pad control bundle
	typedef struct packed {
		logic out;
		logic oe;
		logic pull;
		logic ana;
	} pad_ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage : pinmux_pkg

// ---- pinmux_partner.sv ----
// Board pads and on-chip timer and serial peripheral model
`timescale 1ns/1ps
module pinmux_partner (
	// Clock
	input  wire logic       clk_in,
	// Pad drive from the selector
	input  wire logic [3:0] a_out_in,
	input  wire logic [3:0] a_oe_in,
	input  wire logic [7:0] b_out_in,
	input  wire logic [7:0] b_oe_in,
	input  wire logic [2:0] c_out_in,
	input  wire logic [2:0] c_oe_in,
	// Board levels where nothing drives
	input  wire logic [3:0] a_ext_in,
	input  wire logic [7:0] b_ext_in,
	input  wire logic [2:0] c_ext_in,
	// Resolved pads and peripheral outputs
	output logic      [3:0] a_pad_out,
	output logic      [7:0] b_pad_out,
	output logic      [2:0] c_pad_out,
	output logic            tim_out,
	output logic            sdo_out,
	output logic            sck_out
);
	// A driven pad beats the board level
	assign a_pad_out = (a_oe_in & a_out_in) | (~a_oe_in & a_ext_in);
	assign b_pad_out = (b_oe_in & b_out_in) | (~b_oe_in & b_ext_in);
	assign c_pad_out = (c_oe_in & c_out_in) | (~c_oe_in & c_ext_in);
	// Toggles every cycle so a stale path is caught
	initial tim_out = 1'b0;
	always @(posedge clk_in) begin
		tim_out <= ~tim_out;
	end
	assign sdo_out = ~tim_out;
	assign sck_out = tim_out;
endmodule : pinmux_partner

// ---- port_pin_function_select_tb.sv ----
// Self-checking testbench for the port pin function selector
`timescale 1ns/1ps
module port_pin_function_select_tb;
	logic       clk = 1'b0;
	logic       rst_n = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       nmi_n = 1'b1;
	logic       hv = 1'b0;
	logic       sck_oe = 1'b0;
	logic [3:0] a_ext = 4'h0;
	logic [7:0] b_ext = 8'h01;
	logic [2:0] c_ext = 3'h0;
	logic [7:0] rdata, b_pad, b_out, b_oe, b_pull;
	logic [3:0] a_pad, a_out, a_oe, a_pull, a_ana;
	logic [2:0] c_pad, c_out, c_oe, c_pull, c_ana;
	logic       tim, sdo, sck, tim_in, din, sck_in, nmi_req, prog, irq;
	logic [7:0] exp_q[$];
	logic       rd_dly = 1'b0;
	logic [7:0] d;
	int         seed = 29100;
	int         num_errors = 0;
	int         check_count = 0;

	always #2 clk = ~clk;

	port_pin_function_select u_port_pin_function_select (
		.CLOCK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.PA_PAD_IN(a_pad), .PA_PAD_OUT(a_out), .PA_PAD_OE_OUT(a_oe), .PA_PULL_OUT(a_pull),
		.PA_ANALOG_OUT(a_ana), .PB_PAD_IN(b_pad), .PB_PAD_OUT(b_out), .PB_PAD_OE_OUT(b_oe),
		.PB_PULL_OUT(b_pull), .PC_PAD_IN(c_pad), .PC_PAD_OUT(c_out), .PC_PAD_OE_OUT(c_oe),
		.PC_PULL_OUT(c_pull), .PC_ANALOG_OUT(c_ana), .NMI_N_IN(nmi_n), .TEST_HV_IN(hv),
		.TIMER_OUT_IN(tim), .TIMER_IN_OUT(tim_in), .SPI_DOUT_IN(sdo), .SPI_SCK_IN(sck),
		.SPI_SCK_OE_IN(sck_oe), .SPI_DIN_OUT(din), .SPI_SCK_OUT(sck_in),
		.NMI_REQ_OUT(nmi_req), .PROG_MODE_OUT(prog), .IRQ_OUT(irq)
	);

	pinmux_partner u_pinmux_partner (
		.clk_in(clk), .a_out_in(a_out), .a_oe_in(a_oe), .b_out_in(b_out), .b_oe_in(b_oe),
		.c_out_in(c_out), .c_oe_in(c_oe), .a_ext_in(a_ext), .b_ext_in(b_ext), .c_ext_in(c_ext),
		.a_pad_out(a_pad), .b_pad_out(b_pad), .c_pad_out(c_pad),
		.tim_out(tim), .sdo_out(sdo), .sck_out(sck)
	);

	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// Read data stands only in the cycle after the strobe
	always @(negedge clk) begin
		if (rd_dly) cmp("read data", exp_q.pop_front(), rdata);
		rd_dly = rd;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		#1;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd   <= 1'b0;
		@(posedge clk);
		#1;
	endtask : rd_reg

	// Port B mode fills by shifting; three bits a line, lines six and seven at 14:12 and 17:15
	task automatic pb_mode(input logic [23:0] m);
		wr_reg(pinmux_pkg::PB_MODE_OFS, m[23:16]);
		wr_reg(pinmux_pkg::PB_MODE_OFS, m[15:8]);
		wr_reg(pinmux_pkg::PB_MODE_OFS, m[7:0]);
	endtask : pb_mode

	task automatic do_reset(input logic lvl);
		hv    <= lvl;
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		hv    <= 1'b0;
		#1;
	endtask : do_reset

	initial begin
		#200000;
		num_errors++;
		final_report();
	end

	initial begin
		do_reset(1'b0);
		cmp("reset state", 8'h00, {a_oe, c_oe, irq});
		for (int i = 0; i < 3; i++) begin
			d = 8'($random(seed));
			wr_reg(8'(4 * i), d);
			rd_reg(8'(4 * i), d);
		end
		rd_reg(8'h3c, 8'h00);
		wr_reg(pinmux_pkg::IRQ_STAT_OFS, 8'hff);
		rd_reg(pinmux_pkg::IRQ_STAT_OFS, 8'h00);
		$display("test registers done");
		wr_reg(pinmux_pkg::PA_DATA_OFS, 8'h01);
		wr_reg(pinmux_pkg::PA_MODE_OFS, 8'h06);
		cmp("pa push pull", 8'h03, {a_out[0], a_oe[0]});
		wr_reg(pinmux_pkg::PA_MODE_OFS, 8'h02);
		cmp("pa drain high", 8'h01, {a_oe[0], a_pull[3]});
		wr_reg(pinmux_pkg::PA_DATA_OFS, 8'h00);
		cmp("pa drain low", 8'h01, {a_out[0], a_oe[0]});
		wr_reg(pinmux_pkg::PA_MODE_OFS, 8'hff);
		wr_reg(pinmux_pkg::PC_MODE_OFS, 8'hff);
		pb_mode(24'hffffff);
		cmp("analog", 8'h7f, {c_ana, a_ana});
		cmp("pb no analog", 8'h00, b_oe);
		wr_reg(pinmux_pkg::PA_MODE_OFS, 8'h00);
		wr_reg(pinmux_pkg::PC_MODE_OFS, 8'h00);
		$display("test port a and c modes done");
		wr_reg(pinmux_pkg::PB_DATA_OFS, 8'h80);
		pb_mode(24'h030003);
		cmp("pb push and pull", 8'h07, {b_out[7], b_oe[7], b_pull[0]});
		wr_reg(pinmux_pkg::IRQ_EN_OFS, 8'h10);
		b_ext[0] <= 1'b0;
		repeat (8) if (!irq) @(posedge clk);
		#1 cmp("irq raised", 8'h01, irq);
		rd_reg(pinmux_pkg::IRQ_STAT_OFS, 8'h10);
		wr_reg(pinmux_pkg::IRQ_CLR_OFS, 8'h10);
		cmp("irq cleared", 8'h00, irq);
		wr_reg(pinmux_pkg::IRQ_EN_OFS, 8'h00);
		b_ext[0] <= 1'b1;
		repeat (4) @(posedge clk);
		b_ext[0] <= 1'b0;
		repeat (6) @(posedge clk);
		#1 cmp("irq masked", 8'h00, irq);
		rd_reg(pinmux_pkg::IRQ_STAT_OFS, 8'h10);
		$display("test port b done");
		wr_reg(pinmux_pkg::ALT_CTRL_OFS, 8'h01);
		repeat (3) begin
			@(negedge clk);
			cmp("timer drive", {6'h00, 1'b1, tim}, {6'h00, b_oe[7], b_out[7]});
		end
		repeat (4) begin
			@(posedge clk);
			b_ext[6] <= 1'($random(seed));
			repeat (3) @(posedge clk);
			#1 cmp("timer input", 8'(b_ext[6]), 8'(tim_in));
		end
		pb_mode(24'h036003);
		cmp("timer input off", 8'h00, tim_in);
		$display("test timer done");
		wr_reg(pinmux_pkg::ALT_CTRL_OFS, 8'h02);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			sck_oe   <= i[0];
			c_ext[0] <= 1'($random(seed));
			repeat (3) @(posedge clk);
			@(negedge clk);
			cmp("spi pads", {4'h0, sck_oe, 1'b1, sdo, sck & sck_oe},
				{4'h0, c_oe[2:1], c_out[1], c_out[2] & sck_oe});
			cmp("spi data in", 8'(c_ext[0]), 8'(din));
		end
		$display("test serial done");
		@(posedge clk);
		nmi_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1 cmp("nmi request", 8'h01, nmi_req);
		@(posedge clk);
		nmi_n <= 1'b1;
		$display("test nmi done");
		do_reset(1'b1);
		cmp("prog entry", 8'h01, {nmi_req, prog});
		cmp("config cleared", 8'h00, {b_oe[7], a_oe, c_oe});
		do_reset(1'b0);
		cmp("normal run", 8'h00, prog);
		$display("test reset strap done");
		final_report();
	end
endmodule : port_pin_function_select_tb
